// file: auems_pkg.sv
// Package of offsets, field layouts and reset values for the mask block.
`default_nettype none
package auems_pkg;
  // ==========================================================
  // Register byte offsets.
  localparam logic [11:0] UE_MASK_OFF     = 12'h108;
  localparam logic [11:0] UE_SEVERITY_OFF = 12'h10c;
  localparam logic [11:0] IRQ_STATUS_OFF  = 12'h1f0;
  localparam logic [11:0] IRQ_ENABLE_OFF  = 12'h1f4;
  // ==========================================================
  // Field positions.
  localparam int LINK_PROTOCOL_ERROR_BIT   = 4;
  localparam int SURPRISE_DOWN_BIT         = 5;
  localparam int POISONED_BIT              = 12;
  localparam int FLOW_CONTROL_ERROR_BIT    = 13;
  localparam int COMPLETION_TIMEOUT_BIT    = 14;
  localparam int COMPLETER_ABORT_BIT       = 15;
  localparam int UNEXPECTED_COMPLETION_BIT = 16;
  localparam int RECEIVER_OVERFLOW_BIT     = 17;
  localparam int MALFORMED_BIT             = 18;
  localparam int ECRC_BIT                  = 19;
  localparam int UNSUPPORTED_REQUEST_BIT   = 20;
  localparam int ACCESS_CONTROL_VIOLATION_BIT = 21;
  localparam int DOUBLE_BIT_ERROR_BIT      = 31;
  localparam int IRQ_FATAL_BIT             = 0;
  localparam int IRQ_NONFATAL_BIT          = 1;
  // ==========================================================
  // Writable bits, event bits and reset values.
  localparam logic [31:0] UE_WRITABLE   = 32'h803f3031;
  localparam logic [31:0] UE_EVENTS     = 32'h803f3030;
  localparam logic [31:0] UE_DBIT_ONLY  = 32'h80000000;
  localparam logic [31:0] MASK_RESET    = 32'h00000000;
  localparam logic [31:0] SEV_RESET     = 32'h00062030;
  localparam logic [1:0]  IRQ_RESET     = 2'h0;
endpackage
`default_nettype wire

// file: auems_sticky_reg.sv
// Sticky 32-bit control register that only a cold reset returns to default.
`default_nettype none
module auems_sticky_reg #(
  parameter logic [31:0] RESET_VAL = 32'h00000000,
  parameter logic [31:0] WR_MASK   = 32'h00000000
) (
  input  wire logic        clk_sys,
  input  wire logic        cold_rst,
  input  wire logic        wr_en,
  input  wire logic [31:0] wr_data,
  input  wire logic [31:0] wr_keep,
  output logic      [31:0] q_ff
);
  logic [31:0] wr_bits;

  assign wr_bits = WR_MASK & ~wr_keep;

  // Warm resets leave this register alone so error policy survives them.
  always_ff @(posedge clk_sys)
  begin
    if (cold_rst)
      q_ff <= RESET_VAL;
    else if (wr_en)
      q_ff <= (q_ff & ~wr_bits) | (wr_data & wr_bits);
  end
endmodule // auems_sticky_reg
`default_nettype wire

// file: auems_irq.sv
// Sticky interrupt status with write-one-to-clear, enable and level output.
`default_nettype none
module auems_irq (
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic [1:0] evt,
  input  wire logic       clr_wr,
  input  wire logic [1:0] clr_data,
  input  wire logic       en_wr,
  input  wire logic [1:0] en_data,
  output logic      [1:0] status_ff,
  output logic      [1:0] enable_ff,
  output logic            irq_ff
);
  import auems_pkg::*;

  // A set in the clearing cycle wins, so no event is lost.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      status_ff <= IRQ_RESET;
    else
      status_ff <= (status_ff & ~(clr_wr ? clr_data : 2'h0)) | evt;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      enable_ff <= IRQ_RESET;
    else if (en_wr)
      enable_ff <= en_data;
  end

  // Level follows the registered status, gated by the enable bits, one cycle later.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      irq_ff <= 1'b0;
    else
      irq_ff <= |(status_ff & enable_ff);
  end
endmodule // auems_irq
`default_nettype wire

// file: auems_top.sv
// Uncorrectable error mask and severity bank with APB access and routing.
//
// Register access over APB was left to the implementer.
`default_nettype none
module auems_top (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        cold_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata_ff,
  output logic             pready_ff,
  output logic             pslverr_ff,
  input  wire logic        double_bit_report_enable,
  input  wire logic [31:0] ue_event,
  output logic      [31:0] ue_status_set_ff,
  output logic      [31:0] ue_log_ff,
  output logic             fatal_report_ff,
  output logic             nonfatal_report_ff,
  output logic             irq_ff
);
  import auems_pkg::*;

  // ==========================================================
  // Bus decode.
  logic        any_rst;
  logic        setup;
  logic        access;
  logic        wr_acc;
  logic        hit_mask;
  logic        hit_sev;
  logic        hit_ists;
  logic        hit_ien;
  logic        mapped;
  logic [31:0] dbit_keep;
  logic [31:0] mask_q;
  logic [31:0] sev_q;
  logic [31:0] mask_rd;
  logic [31:0] sev_rd;
  logic [31:0] eff_mask;
  logic [31:0] eff_sev;
  logic [31:0] live_evt;
  logic [1:0]  irq_sts;
  logic [1:0]  irq_en;
  logic [31:0] nxt_prdata;

  assign any_rst  = srst | cold_rst;
  assign setup    = psel & ~penable;
  assign access   = psel & penable & pready_ff;
  assign wr_acc   = access & pwrite;
  assign hit_mask = (paddr == UE_MASK_OFF);
  assign hit_sev  = (paddr == UE_SEVERITY_OFF);
  assign hit_ists = (paddr == IRQ_STATUS_OFF);
  assign hit_ien  = (paddr == IRQ_ENABLE_OFF);
  assign mapped   = hit_mask | hit_sev | hit_ists | hit_ien;

  // While double-bit reporting is off, bit 31 keeps its old value.
  assign dbit_keep = double_bit_report_enable ? 32'h0 : UE_DBIT_ONLY;

  // ==========================================================
  // Sticky mask and severity storage.
  auems_sticky_reg #(
    .RESET_VAL (MASK_RESET),
    .WR_MASK   (UE_WRITABLE)
  ) u_mask (
    .clk_sys  (clk_sys),
    .cold_rst (cold_rst),
    .wr_en    (wr_acc & hit_mask),
    .wr_data  (pwdata),
    .wr_keep  (dbit_keep),
    .q_ff     (mask_q)
  );

  auems_sticky_reg #(
    .RESET_VAL (SEV_RESET),
    .WR_MASK   (UE_WRITABLE)
  ) u_sev (
    .clk_sys  (clk_sys),
    .cold_rst (cold_rst),
    .wr_en    (wr_acc & hit_sev),
    .wr_data  (pwdata),
    .wr_keep  (dbit_keep),
    .q_ff     (sev_q)
  );

  // The stored double-bit value is hidden, not lost, when reporting is off.
  assign mask_rd = mask_q & ~dbit_keep;
  assign sev_rd  = sev_q & ~dbit_keep;

  // ==========================================================
  // Event routing.
  assign live_evt = ue_event & UE_EVENTS;
  assign eff_mask = mask_rd & UE_EVENTS;
  assign eff_sev  = sev_rd & UE_EVENTS;

  always_ff @(posedge clk_sys)
  begin
    if (any_rst)
      ue_status_set_ff <= 32'h0;
    else
      ue_status_set_ff <= live_evt;
  end

  always_ff @(posedge clk_sys)
  begin
    if (any_rst)
      ue_log_ff <= 32'h0;
    else
      ue_log_ff <= live_evt & ~eff_mask;
  end

  always_ff @(posedge clk_sys)
  begin
    if (any_rst)
    begin
      fatal_report_ff    <= 1'b0;
      nonfatal_report_ff <= 1'b0;
    end
    else
    begin
      fatal_report_ff    <= |(live_evt & ~eff_mask & eff_sev);
      nonfatal_report_ff <= |(live_evt & ~eff_mask & ~eff_sev);
    end
  end

  // ==========================================================
  // Interrupt on reported errors.
  auems_irq u_irq (
    .clk_sys   (clk_sys),
    .srst      (any_rst),
    .evt       ({nonfatal_report_ff, fatal_report_ff}),
    .clr_wr    (wr_acc & hit_ists),
    .clr_data  (pwdata[1:0]),
    .en_wr     (wr_acc & hit_ien),
    .en_data   (pwdata[1:0]),
    .status_ff (irq_sts),
    .enable_ff (irq_en),
    .irq_ff    (irq_ff)
  );

  // ==========================================================
  // APB answer: one wait-free access cycle after each setup.
  always_comb
  begin
    nxt_prdata = 32'h0;
    case (1'b1)
      hit_mask: nxt_prdata = mask_rd;
      hit_sev:  nxt_prdata = sev_rd;
      hit_ists: nxt_prdata = {30'h0, irq_sts};
      hit_ien:  nxt_prdata = {30'h0, irq_en};
      default:  nxt_prdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (any_rst)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0;
    end
    else
    begin
      pready_ff  <= setup;
      pslverr_ff <= setup & ~mapped;
      prdata_ff  <= (setup & ~pwrite) ? nxt_prdata : 32'h0;
    end
  end

  // ==========================================================
  // Checks.
  sequence s_mask_setup;
    psel && !penable && !pwrite && hit_mask;
  endsequence

  sequence s_sev_setup;
    psel && !penable && !pwrite && hit_sev;
  endsequence

  sequence s_answer_dbit_zero;
    pready_ff && !prdata_ff[DOUBLE_BIT_ERROR_BIT];
  endsequence

  property p_masked_silent;
    @(posedge clk_sys) disable iff (any_rst)
      (|(live_evt & eff_mask)) |=>
        ((ue_log_ff & $past(eff_mask)) == 32'h0);
  endproperty
  a_masked_silent: assert property (p_masked_silent)
    else $error("masked event was logged");

  property p_status_kept;
    @(posedge clk_sys) disable iff (any_rst)
      1'b1 |=> (ue_status_set_ff == $past(live_evt));
  endproperty
  a_status_kept: assert property (p_status_kept)
    else $error("status set did not follow the event");

  property p_dbit_unmasked_off;
    @(posedge clk_sys) disable iff (any_rst)
      (ue_event[DOUBLE_BIT_ERROR_BIT] && !double_bit_report_enable)
        |=> ue_log_ff[DOUBLE_BIT_ERROR_BIT];
  endproperty
  a_dbit_unmasked_off: assert property (p_dbit_unmasked_off)
    else $error("double-bit event masked while reporting off");

  property p_dbit_read_zero;
    @(posedge clk_sys) disable iff (any_rst)
      (s_mask_setup and !double_bit_report_enable) |=> s_answer_dbit_zero;
  endproperty
  a_dbit_read_zero: assert property (p_dbit_read_zero)
    else $error("double-bit mask read nonzero while off");

  property p_sev_read_zero;
    @(posedge clk_sys) disable iff (any_rst)
      (s_sev_setup and !double_bit_report_enable) |=> s_answer_dbit_zero;
  endproperty
  a_sev_read_zero: assert property (p_sev_read_zero)
    else $error("double-bit severity read nonzero while off");

  // A write while reporting is off must leave the hidden bit untouched.
  property p_dbit_write_kept;
    @(posedge clk_sys) disable iff (any_rst)
      (wr_acc && (hit_mask || hit_sev) && !double_bit_report_enable) |=>
        (((mask_q ^ $past(mask_q)) & UE_DBIT_ONLY) == 32'h0) &&
        (((sev_q ^ $past(sev_q)) & UE_DBIT_ONLY) == 32'h0);
  endproperty
  a_dbit_write_kept: assert property (p_dbit_write_kept)
    else $error("double-bit bit written while reporting off");

  property p_mask_reserved;
    @(posedge clk_sys) disable iff (cold_rst)
      (mask_q & ~UE_WRITABLE) == 32'h0;
  endproperty
  a_mask_reserved: assert property (p_mask_reserved)
    else $error("reserved mask bit set");

  property p_fatal_route;
    @(posedge clk_sys) disable iff (any_rst)
      (|(live_evt & ~eff_mask & eff_sev)) |=>
        fatal_report_ff ##1 irq_sts[IRQ_FATAL_BIT];
  endproperty
  a_fatal_route: assert property (p_fatal_route)
    else $error("fatal event not reported and latched");

  property p_sev_reserved;
    @(posedge clk_sys) disable iff (cold_rst)
      (sev_q[COMPLETER_ABORT_BIT:COMPLETION_TIMEOUT_BIT] == 2'h0) &&
      ((sev_q & ~UE_WRITABLE) == 32'h0);
  endproperty
  a_sev_reserved: assert property (p_sev_reserved)
    else $error("hard-wired severity bit set");

  property p_sev_reset;
    @(posedge clk_sys)
      cold_rst |=> (sev_q == SEV_RESET) && (mask_q == MASK_RESET);
  endproperty
  a_sev_reset: assert property (p_sev_reset)
    else $error("cold reset defaults wrong");

  property p_bit0_inert;
    @(posedge clk_sys) disable iff (any_rst)
      (ue_event == 32'h1) |=> !fatal_report_ff && !nonfatal_report_ff;
  endproperty
  a_bit0_inert: assert property (p_bit0_inert)
    else $error("bit zero caused a report");

  property p_warm_keeps;
    @(posedge clk_sys)
      (srst && !cold_rst) |=>
        (mask_q == $past(mask_q)) && (sev_q == $past(sev_q));
  endproperty
  a_warm_keeps: assert property (p_warm_keeps)
    else $error("warm reset changed sticky bits");

  property p_nonfatal_route;
    @(posedge clk_sys) disable iff (any_rst)
      (|(live_evt & ~eff_mask & ~eff_sev)) |=>
        nonfatal_report_ff ##1 irq_sts[IRQ_NONFATAL_BIT];
  endproperty
  a_nonfatal_route: assert property (p_nonfatal_route)
    else $error("non-fatal event not reported and latched");

  property p_masked_no_report;
    @(posedge clk_sys) disable iff (any_rst)
      ((live_evt != 32'h0) && ((live_evt & ~eff_mask) == 32'h0)) |=>
        (!fatal_report_ff && !nonfatal_report_ff);
  endproperty
  a_masked_no_report: assert property (p_masked_no_report)
    else $error("fully masked event was reported");

  property p_unmapped_error;
    @(posedge clk_sys) disable iff (any_rst)
      (psel && !penable && !mapped) |=>
        (pready_ff && pslverr_ff && (prdata_ff == 32'h0));
  endproperty
  a_unmapped_error: assert property (p_unmapped_error)
    else $error("unmapped access not refused");
endmodule // auems_top
`default_nettype wire

// file: auems_bench.sv
// Self-checking bench for the uncorrectable error mask and severity bank.
`default_nettype none
module auems_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import auems_pkg::*;

  // ==========================================================
  // Stimulus, observation and model state.
  localparam logic [31:0] WR_BITS = 32'h803f3031;
  localparam logic [31:0] EV_BITS = 32'h803f3030;
  logic        clk_sys  = 1'b0;
  logic        srst     = 1'b1;
  logic        cold_rst = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [11:0] paddr    = 12'h000;
  logic [31:0] pwdata   = 32'h00000000;
  logic        dbr_en   = 1'b1;
  logic [31:0] ue_event = 32'h00000000;
  logic [31:0] prdata_ff;
  logic [31:0] ue_status_set_ff;
  logic [31:0] ue_log_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        fatal_report_ff;
  logic        nonfatal_report_ff;
  logic        irq_ff;
  logic [31:0] seed = 32'h0000e7ec;
  logic [31:0] mask_m;
  logic [31:0] sev_m;
  logic [31:0] rd;
  logic [31:0] r;
  logic        err;
  int          error_cnt = 0;
  int          samples_checked = 0;

  always #5 clk_sys = ~clk_sys;

  auems_top auems_top_i (
    .clk_sys                  (clk_sys),
    .srst                     (srst),
    .cold_rst                 (cold_rst),
    .psel                     (psel),
    .penable                  (penable),
    .pwrite                   (pwrite),
    .paddr                    (paddr),
    .pwdata                   (pwdata),
    .prdata_ff                (prdata_ff),
    .pready_ff                (pready_ff),
    .pslverr_ff               (pslverr_ff),
    .double_bit_report_enable (dbr_en),
    .ue_event                 (ue_event),
    .ue_status_set_ff         (ue_status_set_ff),
    .ue_log_ff                (ue_log_ff),
    .fatal_report_ff          (fatal_report_ff),
    .nonfatal_report_ff       (nonfatal_report_ff),
    .irq_ff                   (irq_ff)
  );

  // ==========================================================
  // Helpers.
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // The top bit only counts while double-bit reporting is on.
  function automatic logic [31:0] gate(input logic [31:0] v);
    return dbr_en ? v : (v & 32'h7fffffff);
  endfunction

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Pready is read right after the rising edge, before the slave's own
  // updates land, so the value seen is the one that edge sampled.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready_ff !== 1'b1 && n < 16);
    if (pready_ff !== 1'b1)
    begin
      error_cnt++;
      finish_test();
    end
    rd = prdata_ff;
    err = pslverr_ff;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] nv;
    nv = d & WR_BITS;
    if (!dbr_en)
      nv[31] = (a == UE_MASK_OFF) ? mask_m[31] : sev_m[31];
    apb(1'b1, a, d);
    if (a == UE_MASK_OFF)
      mask_m = nv;
    else if (a == UE_SEVERITY_OFF)
      sev_m = nv;
  endtask

  task automatic rreg(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, err}, 32'h0);
  endtask

  task automatic rmodel();
    rreg(UE_MASK_OFF, gate(mask_m));
    rreg(UE_SEVERITY_OFF, gate(sev_m));
  endtask

  task automatic set_en(input logic v);
    @(posedge clk_sys);
    dbr_en <= v;
    #1;
  endtask

  task automatic fire(input logic [31:0] v);
    logic [31:0] ev;
    logic [31:0] lg;
    ev = v & EV_BITS;
    lg = ev & ~gate(mask_m);
    @(posedge clk_sys);
    ue_event <= v;
    @(posedge clk_sys);
    ue_event <= 32'h0;
    #1;
    chk(ue_status_set_ff, ev);
    chk(ue_log_ff, lg);
    chk({31'h0, fatal_report_ff}, {31'h0, |(lg & gate(sev_m))});
    chk({31'h0, nonfatal_report_ff}, {31'h0, |(lg & ~gate(sev_m))});
  endtask

  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (irq_ff !== lvl && n < 8)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk({31'h0, irq_ff}, {31'h0, lvl});
    if (irq_ff !== lvl)
      finish_test();
  endtask

  // ==========================================================
  // Main sequence.
  initial
  begin
    mask_m = 32'h0;
    sev_m = 32'h00062030;
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    cold_rst <= 1'b0;
    rmodel();
    $display("test cold reset done");
    wreg(UE_MASK_OFF, 32'hffffffff);
    wreg(UE_SEVERITY_OFF, 32'hffffffff);
    rmodel();
    fire(32'hffffffff);
    fire(32'h00000001);
    set_en(1'b0);
    rmodel();
    fire(32'hffffffff);
    wreg(UE_MASK_OFF, 32'h0);
    wreg(UE_SEVERITY_OFF, 32'h0);
    set_en(1'b1);
    rmodel();
    $display("test layout and gating done");
    for (int i = 0; i < 48; i++)
    begin
      r = xs();
      set_en(r[0]);
      wreg(r[1] ? UE_MASK_OFF : UE_SEVERITY_OFF, xs());
      r = xs();
      fire(r);
      if (r[3])
        rmodel();
    end
    $display("test random traffic done");
    apb(1'b1, 12'h200, 32'hffffffff);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 12'h200, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    rmodel();
    $display("test unmapped access done");
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    rmodel();
    $display("test warm reset done");
    set_en(1'b1);
    wreg(UE_MASK_OFF, 32'h0);
    wreg(UE_SEVERITY_OFF, 32'h10);
    wreg(IRQ_ENABLE_OFF, 32'h3);
    fire(32'h10);
    wait_irq(1'b1);
    rreg(IRQ_STATUS_OFF, 32'h1);
    wreg(IRQ_STATUS_OFF, 32'h1);
    rreg(IRQ_STATUS_OFF, 32'h0);
    wait_irq(1'b0);
    wreg(IRQ_ENABLE_OFF, 32'h0);
    fire(32'h10000);
    repeat (4) @(negedge clk_sys);
    chk({31'h0, irq_ff}, 32'h0);
    rreg(IRQ_STATUS_OFF, 32'h2);
    wreg(IRQ_ENABLE_OFF, 32'h2);
    wait_irq(1'b1);
    wreg(IRQ_STATUS_OFF, 32'h2);
    wait_irq(1'b0);
    $display("test interrupt done");
    wreg(UE_MASK_OFF, 32'hffffffff);
    @(posedge clk_sys);
    cold_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    cold_rst <= 1'b0;
    mask_m = MASK_RESET;
    sev_m = SEV_RESET;
    rmodel();
    rreg(IRQ_ENABLE_OFF, 32'h0);
    $display("test second cold reset done");
    finish_test();
  end
endmodule // auems_bench
`default_nettype wire
